// File: epb_pkg.sv
// constants, codes and types for the enhanced pwm bridge output stage
// Notes on behaviour
// R1: duty is 10 bits: eight msbs in duty_msb_reg, two lsbs in control bits 5:4.
// R2: duty writes accepted anytime; shadow copy loads only at the period match.
// R3: shadow duty register ignores software writes while in pwm mode.
// R4: pwm clears when shadow duty equals period timer extended by two sub-tick bits.
// R5: duty longer than the period never clears the output in that period.
// R6: active time is duty times oscillator period times prescale 1, 4 or 16.
// R7: a two-bit field selects single, half-bridge, full forward or full reverse.
// R8: single configuration gives one pwm waveform on output a only.
// R9: half-bridge drives pwm on output a and its complement on output b.
// R10: half-bridge delays only inactive-to-active edges by the dead band count.
// R11: dead band count is seven bits, in instruction cycles of four clocks.
// R12: dead band longer than the active time keeps that output inactive all cycle.
// R13: full forward holds a active, modulates d, keeps b and c inactive.
// R14: full reverse holds c active, modulates b, keeps a and d inactive.
// R15: a new direction takes effect from the next pwm cycle.
// R16: pending reversal switches fixed outputs one timer tick before the boundary.
// R17: from that early switch to the boundary both modulated outputs stay inactive.
// R18: full-bridge outputs have no dead band on any edge.
// R19: direction bit 7 may be written anytime and is accepted at once.
// R20: software should lower duty one period before reversing at high duty.
// R21: on timer-period match next tick clears timer, sets pwm unless zero, loads shadow.
// R22: settings load at period boundary; dead band loads at duty or period boundary.
// R23: two polarity bits pick active level for pair a/c and pair b/d.
// R24: field codes 00 single, 10 half, 01 forward, 11 reverse; upper bit is direction.
// R25: reset gives inactive outputs, clear duty and dead band; zero dead band means none.
package epb_pkg;

    // ****************************************
    // register map and reset values
    // ****************************************
    localparam logic [2:0] ADDR_DUTY_MSB   = 3'h0;
    localparam logic [2:0] ADDR_CONTROL    = 3'h1;
    localparam logic [2:0] ADDR_PERIOD     = 3'h2;
    localparam logic [2:0] ADDR_DEADBAND   = 3'h3;
    localparam logic [2:0] ADDR_TIMER_CTRL = 3'h4;
    localparam logic [2:0] ADDR_SHADOW     = 3'h5;
    localparam logic [2:0] ADDR_TIMER      = 3'h6;

    localparam logic [7:0] RST_DUTY_MSB    = 8'h00;
    localparam logic [7:0] RST_CONTROL     = 8'h00;
    localparam logic [7:0] RST_PERIOD      = 8'hFF;
    localparam logic [6:0] RST_DEADBAND    = 7'h00;
    localparam logic [2:0] RST_TIMER_CTRL  = 3'h0;
    localparam int         DB_WIDTH        = 7;
    localparam int         TCTRL_ON_BIT    = 2;

    // ****************************************
    // codes
    // ****************************************
    localparam logic [1:0] CFG_SINGLE = 2'h0; // R24
    localparam logic [1:0] CFG_HALF   = 2'h2;
    localparam logic [1:0] CFG_FWD    = 2'h1;
    localparam logic [1:0] CFG_REV    = 2'h3;
    localparam logic [1:0] MODE_PWM   = 2'h3;
    localparam logic [1:0] PS_SEL_1   = 2'h0;
    localparam logic [1:0] PS_SEL_4   = 2'h1;

    // ****************************************
    // timing: one clock is one oscillator period
    // ****************************************
    localparam int         TOSC_NS        = 100;
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         CLKS_PER_TOSC  = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         INSTR_TOSC     = 4;
    localparam int         CLKS_PER_INSTR = INSTR_TOSC * CLKS_PER_TOSC;
    localparam logic [5:0] FINE_LAST_PS1  = 6'(CLKS_PER_INSTR * 1 - 1);
    localparam logic [5:0] FINE_LAST_PS4  = 6'(CLKS_PER_INSTR * 4 - 1);
    localparam logic [5:0] FINE_LAST_PS16 = 6'(CLKS_PER_INSTR * 16 - 1);

    // control register layout, msb first
    typedef struct packed {
        logic [1:0] cfg;
        logic [1:0] duty_lsb;
        logic [1:0] mode_hi;
        logic [1:0] pol;
    } epb_ctrl_type;

endpackage

// File: epb_bridge.sv
// enhanced pwm bridge output stage with register port
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module epb_bridge
    import epb_pkg::*;
#(
    parameter int DB_W = DB_WIDTH
)
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output var  logic [7:0] o_rd_data,
    output var  logic       o_out_a,
    output var  logic       o_out_b,
    output var  logic       o_out_c,
    output var  logic       o_out_d
);

    // ****************************************
    // elaboration check
    // ****************************************
    generate
        if (DB_W < 1 || DB_W > DB_WIDTH)
        begin : g_bad_db
            $error("dead band width out of range");
        end
    endgenerate

    // ****************************************
    // decode functions
    // ****************************************
    function automatic logic [5:0] fine_last(input logic [1:0] sel);
        logic [5:0] r;
        r = (sel == PS_SEL_1) ? FINE_LAST_PS1 : (sel == PS_SEL_4) ? FINE_LAST_PS4 : FINE_LAST_PS16;
        return r;
    endfunction

    // two bits below the timer, in units of one prescaled oscillator period
    function automatic logic [1:0] sub_bits(input logic [5:0] fine, input logic [1:0] sel);
        logic [1:0] r;
        r = (sel == PS_SEL_1) ? fine[1:0] : (sel == PS_SEL_4) ? fine[3:2] : fine[5:4];
        return r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [7:0]          duty_msb_q;
    epb_ctrl_type        ctrl_q;
    logic [7:0]          period_q;
    logic [DB_W-1:0]     db_reg_q;
    logic [2:0]          tctrl_q;
    logic [7:0]          shadow_q;
    logic [1:0]          shadow_lsb_q;
    logic [1:0]          cfg_q;
    logic [1:0]          pol_q;
    logic [DB_W-1:0]     db_q;
    logic [5:0]          fine_q;
    logic [7:0]          timer_q;
    logic                pwm_raw_q;
    logic [DB_W+1:0]     dbc_q [2];
    logic [3:0]          out_q;
    logic [7:0]          rd_q;

    // ****************************************
    // decode
    // ****************************************
    wire                 wr_duty     = i_wr && i_addr == ADDR_DUTY_MSB;
    wire                 wr_ctrl     = i_wr && i_addr == ADDR_CONTROL;
    wire                 wr_period   = i_wr && i_addr == ADDR_PERIOD;
    wire                 wr_db       = i_wr && i_addr == ADDR_DEADBAND;
    wire                 wr_tctrl    = i_wr && i_addr == ADDR_TIMER_CTRL;
    wire                 wr_shadow   = i_wr && i_addr == ADDR_SHADOW;
    wire                 pwm_en      = ctrl_q.mode_hi == MODE_PWM;
    wire                 tmr_on      = tctrl_q[TCTRL_ON_BIT];
    wire [1:0]           ps_sel      = tctrl_q[1:0];
    wire [9:0]           duty_live   = {duty_msb_q, ctrl_q.duty_lsb}; // R1
    wire [1:0]           sub         = sub_bits(fine_q, ps_sel);
    wire                 tick_end    = tmr_on && fine_q == fine_last(ps_sel);
    wire                 last_tick   = tmr_on && timer_q == period_q;
    wire                 boundary    = tick_end && last_tick; // R21
    wire                 match       = pwm_en && {timer_q, sub} == {shadow_q, shadow_lsb_q}; // R4 R5
    // pwm drops in the match cycle itself so the high time is exactly duty units
    wire                 pwm_on      = pwm_raw_q && !match; // R6
    wire                 load_cfg    = boundary || !pwm_en; // R22
    wire                 full_now    = cfg_q[0] && ctrl_q.cfg[0];
    // reversal pending: switch fixed outputs for the whole last tick
    wire                 early       = pwm_en && full_now && ctrl_q.cfg[1] != cfg_q[1] && last_tick; // R16 R17
    wire                 dir         = early ? ctrl_q.cfg[1] : cfg_q[1]; // R15
    wire                 mod         = pwm_on && !early; // R17
    wire [DB_W+1:0]      db_clks     = {db_q, 2'b00}; // R11
    wire [1:0]           hb_src      = {pwm_en && !pwm_on, pwm_on}; // R9

    // ****************************************
    // timer and duty
    // ****************************************
    wire [5:0]           fine_d      = tick_end ? 6'h00 : fine_q + 6'h01;
    wire [7:0]           timer_d     = boundary ? 8'h00 : timer_q + 8'h01;
    wire                 pwm_raw_d   = !pwm_en ? 1'b0 :
                                       boundary ? duty_live != 10'h000 : // R21 R6
                                       match ? 1'b0 : pwm_raw_q; // R4

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            fine_q    <= 6'h00;
            timer_q   <= 8'h00;
            pwm_raw_q <= 1'b0;
        end
        else if (i_ce && tmr_on)
        begin
            fine_q    <= fine_d;
            timer_q   <= tick_end ? timer_d : timer_q;
            pwm_raw_q <= pwm_raw_d;
        end
        else if (i_ce)
        begin
            pwm_raw_q <= pwm_en && pwm_raw_q;
        end
    end

    // ****************************************
    // software registers, accepted at any time
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            duty_msb_q <= RST_DUTY_MSB;
            ctrl_q     <= RST_CONTROL;
            period_q   <= RST_PERIOD;
            db_reg_q   <= DB_W'(RST_DEADBAND);
            tctrl_q    <= RST_TIMER_CTRL;
        end
        else if (i_ce)
        begin
            if (wr_duty)
                duty_msb_q <= i_wr_data; // R2
            if (wr_ctrl)
                ctrl_q <= i_wr_data; // R19 R7
            if (wr_period)
                period_q <= i_wr_data;
            if (wr_db)
                db_reg_q <= i_wr_data[DB_W-1:0]; // R11
            if (wr_tctrl)
                tctrl_q <= i_wr_data[2:0];
        end
    end

    // ****************************************
    // double buffers
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            shadow_q     <= 8'h00;
            shadow_lsb_q <= 2'h0;
            cfg_q        <= CFG_SINGLE;
            pol_q        <= 2'h0;
            db_q         <= '0;
        end
        else if (i_ce)
        begin
            if (boundary)
            begin
                shadow_q     <= duty_msb_q; // R2 R21
                shadow_lsb_q <= ctrl_q.duty_lsb;
            end
            else if (wr_shadow && !pwm_en)
            begin
                // writable only outside pwm mode
                shadow_q <= i_wr_data; // R3
            end
            if (load_cfg)
            begin
                cfg_q <= ctrl_q.cfg; // R22
                pol_q <= ctrl_q.pol;
            end
            if (boundary || match || !pwm_en)
                db_q <= db_reg_q; // R22
        end
    end

    // ****************************************
    // dead band, rising edges only
    // ****************************************
    logic [1:0] hb_act;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_db
            // saturating count, compared with >= so a shrinking count is safe
            assign hb_act[gi] = hb_src[gi] && dbc_q[gi] >= db_clks; // R10 R12 R25
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_b)
                    dbc_q[gi] <= '0;
                else if (i_ce)
                    dbc_q[gi] <= !hb_src[gi] ? '0 : hb_act[gi] ? dbc_q[gi] : dbc_q[gi] + 1'b1; // R10
            end
        end
    endgenerate

    // ****************************************
    // output steering, bit order a b c d = 0..3
    // ****************************************
    logic [3:0] act_d;

    always_comb
    begin
        act_d = 4'h0;
        if (pwm_en)
        begin
            case (cfg_q)
                CFG_SINGLE: act_d[0] = pwm_on; // R8
                CFG_HALF:   act_d[1:0] = hb_act; // R9 R10
                CFG_FWD, CFG_REV:
                begin
                    // no dead band in either bridge direction
                    if (!dir)
                    begin
                        act_d[0] = 1'b1; // R13 R18
                        act_d[3] = mod;
                    end
                    else
                    begin
                        act_d[2] = 1'b1; // R14 R18
                        act_d[1] = mod;
                    end
                end
                default: act_d = 4'h0;
            endcase
        end
    end

    wire [3:0] pol_mask = {pol_q[0], pol_q[1], pol_q[0], pol_q[1]}; // R23
    wire [3:0] out_d    = act_d ^ pol_mask;

    // ****************************************
    // read port
    // ****************************************
    wire [7:0] rd_mux =
        i_addr == ADDR_DUTY_MSB   ? duty_msb_q :
        i_addr == ADDR_CONTROL    ? ctrl_q :
        i_addr == ADDR_PERIOD     ? period_q :
        i_addr == ADDR_DEADBAND   ? 8'(db_reg_q) :
        i_addr == ADDR_TIMER_CTRL ? {5'h00, tctrl_q} :
        i_addr == ADDR_SHADOW     ? shadow_q :
        i_addr == ADDR_TIMER      ? timer_q : 8'h00;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            out_q <= 4'h0; // R25
            rd_q  <= 8'h00;
        end
        else if (i_ce)
        begin
            out_q <= out_d;
            rd_q  <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rd_data = rd_q;
    assign o_out_a   = out_q[0];
    assign o_out_b   = out_q[1];
    assign o_out_c   = out_q[2];
    assign o_out_d   = out_q[3];

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    wire [3:0] act_q = out_q ^ pol_mask;

    chk_shadow_load: assert property (i_ce && boundary |=> {shadow_q, shadow_lsb_q} == $past(duty_live)) // R2
        else $error("shadow duty not loaded at boundary");
    chk_shadow_ro: assert property (i_ce && pwm_en && wr_shadow && !boundary |=> $stable(shadow_q)) // R3
        else $error("shadow duty changed by write in pwm mode");
    chk_clear_match: assert property (i_ce && match && !boundary |=> !pwm_raw_q) // R4
        else $error("pwm not cleared on duty match");
    chk_set_boundary: assert property (i_ce && pwm_en && boundary |=> pwm_raw_q == ($past(duty_live) != 10'h000)) // R21
        else $error("pwm start level wrong at boundary");
    chk_timer_wrap: assert property (i_ce && boundary |=> timer_q == 8'h00 && fine_q == 6'h00) // R21
        else $error("timer not cleared at period match");
    chk_half_excl: assert property (cfg_q == CFG_HALF |-> !(act_d[0] && act_d[1])) // R9
        else $error("half bridge outputs both active");
    chk_dead_delay: assert property (i_ce && pwm_en && cfg_q == CFG_HALF && db_q != '0 && hb_src[0]
                                     && dbc_q[0] == '0 ##1 i_ce |=> !act_q[0]) // R10
        else $error("dead band not applied to rising edge");
    chk_fwd_outs: assert property (pwm_en && cfg_q == CFG_FWD && !early |-> act_d[0] && !act_d[1] && !act_d[2]) // R13
        else $error("forward bridge pattern wrong");
    chk_rev_outs: assert property (pwm_en && cfg_q == CFG_REV && !early |-> act_d[2] && !act_d[0] && !act_d[3]) // R14
        else $error("reverse bridge pattern wrong");
    chk_early_off: assert property (early |-> !act_d[1] && !act_d[3] && act_d[0] == !ctrl_q.cfg[1]) // R16 R17
        else $error("modulated outputs active during direction change");

    cov_period: cover property (i_ce && boundary && duty_live != 10'h000);
    cov_half_b: cover property (cfg_q == CFG_HALF && $rose(act_q[1]));
    cov_reverse: cover property (early ##1 !early);

endmodule

`default_nettype wire

// File: epb_switch_model.sv
// power switch driver model: on-time of each bridge pin and leg shoot-through count
`timescale 1ns/1ps
`default_nettype none

module epb_switch_model
(
    input  wire logic        i_clk,
    input  wire logic        i_win,
    input  wire logic [1:0]  i_pol,
    input  wire logic [3:0]  i_pins,
    output var  logic [15:0] o_on [4],
    output var  logic [15:0] o_shoot
);
    // ****************************************
    // active level per pin, pins are d c b a
    // ****************************************
    wire logic [3:0] on = i_pins ^ {i_pol[0], i_pol[1], i_pol[0], i_pol[1]};

    always_ff @(posedge i_clk)
    begin
        if (!i_win)
        begin
            o_on    <= '{default: 16'h0000};
            o_shoot <= 16'h0000;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
                o_on[k] <= o_on[k] + 16'(on[k]);
            // both switches of one leg on at once shorts the supply
            o_shoot <= o_shoot + 16'((on[0] & on[1]) | (on[2] & on[3]));
        end
    end
endmodule

`default_nettype wire

// File: enhanced_pwm_bridge_output_test.sv
// self-checking bench for the enhanced pwm bridge output stage
`timescale 1ns/1ps
`default_nettype none

module enhanced_pwm_bridge_output_test
    import epb_pkg::*;
;
    localparam logic [7:0] MSK [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h07};
    logic        i_clk, i_rst_b, i_wr, i_rd, win;
    logic [2:0]  i_addr, a;
    logic [7:0]  i_wr_data, v, d;
    logic [1:0]  pol;
    logic [7:0]  rv [8];
    wire  [7:0]  o_rd_data;
    wire  [3:0]  pins;
    wire  [15:0] on_cnt [4];
    wire  [15:0] shoot;
    int          num_errors, checks, per, sd;

    epb_bridge epb_bridge_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_out_a(pins[0]),
        .o_out_b(pins[1]), .o_out_c(pins[2]), .o_out_d(pins[3]));
    epb_switch_model epb_switch_model_i (.i_clk(i_clk), .i_win(win), .i_pol(pol), .i_pins(pins),
        .o_on(on_cnt), .o_shoot(shoot));

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wr_data <= dt;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] ad, output logic [7:0] dt);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 dt = o_rd_data;
    endtask

    task automatic rst(input int n);
        i_rst_b <= 1'b0;
        repeat (n) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        #1;
        check("pins after reset", 16'(pins), 16'h0000);
    endtask

    // bounded wait for a pin level
    task automatic wait_pin(input int k, input logic lvl, input int bound);
        int n;
        n = 0;
        while (pins[k] !== lvl && n < bound)
        begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n >= bound)
        begin
            num_errors++;
            $display("[ERR] wait on pin %0d ran out", k);
            give_verdict();
        end
    endtask

    // expected on-clocks of pin k in one period
    function automatic int exp_on(input logic [1:0] cfg, input int k, input int du, input int ps,
                                  input int pr, input int db);
        int t, dd, g;
        t = (pr + 1) * 4 * ps;
        dd = (du * ps > t) ? t : du * ps;
        g = 4 * db;
        case (cfg)
            CFG_SINGLE: return (k == 0) ? dd : 0;
            CFG_HALF:   return (k == 0) ? ((dd >= t) ? t : (dd > g) ? dd - g : 0) :
                               (k == 1) ? ((dd == 0) ? t : (t - dd > g) ? t - dd - g : 0) : 0;
            CFG_FWD:    return (k == 0) ? t : (k == 3) ? dd : 0;
            default:    return (k == 2) ? t : (k == 1) ? dd : 0;
        endcase
    endfunction

    task automatic run(input logic [1:0] cfg, input int du, input logic [1:0] pss, input int pr,
                       input int db, input logic [1:0] pp);
        int ps, t;
        ps = (pss == PS_SEL_1) ? 1 : (pss == PS_SEL_4) ? 4 : 16;
        t = (pr + 1) * 4 * ps;
        @(posedge i_clk);
        rst(2);
        pol <= pp;
        wr(ADDR_PERIOD, 8'(pr));
        wr(ADDR_DEADBAND, 8'(db));
        wr(ADDR_DUTY_MSB, 8'(du >> 2));
        wr(ADDR_CONTROL, {cfg, 2'(du), MODE_PWM, pp});
        wr(ADDR_TIMER_CTRL, {5'h00, 1'b1, pss});
        repeat (2 * t + 8) @(posedge i_clk);
        win <= 1'b1;
        repeat (2 * t) @(posedge i_clk);
        win <= 1'b0;
        #1;
        for (int k = 0; k < 4; k++)
            check($sformatf("pin %0d on-time", k), on_cnt[k], 16'(2 * exp_on(cfg, k, du, ps, pr, db)));
        check("shoot-through", shoot, 16'h0000);
        $display("test cfg %b duty %0d ps %0d period %0d db %0d done", cfg, du, ps, pr, db);
    endtask

    // low duty before each reversal keeps the legs safe
    task automatic dir_change(input logic [1:0] to, input int ps);
        int fx, md, n, bad;
        fx = (to == CFG_REV) ? 2 : 0;
        md = (to == CFG_REV) ? 1 : 3;
        wait_pin(4 - md, 1'b1, 200 * ps);
        wait_pin(4 - md, 1'b0, 200 * ps);
        repeat ($urandom_range(0, 8)) @(posedge i_clk);
        wr(ADDR_CONTROL, {to, 2'h0, MODE_PWM, 2'h0});
        wait_pin(fx, 1'b1, 200 * ps);
        check("old fixed pin off", 16'(pins[2 - fx]), 16'h0000);
        n = 0;
        bad = 0;
        while (pins[md] !== 1'b1 && n < 200)
        begin
            bad += (pins[4 - md] !== 1'b0);
            @(posedge i_clk);
            #1 n++;
        end
        check("early switch lead", 16'(n), 16'(4 * ps));
        check("modulated pins idle", 16'(bad), 16'h0000);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        i_rst_b = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wr_data = 8'h00;
        win = 1'b0;
        pol = 2'h0;
        sd = $urandom(32'hD9C2);
        rv = '{RST_DUTY_MSB, RST_CONTROL, RST_PERIOD, {1'b0, RST_DEADBAND}, {5'h00, RST_TIMER_CTRL},
               8'h00, 8'h00, 8'h00};
        rst(20);
        for (int k = 0; k < 8; k++)
        begin
            rd(3'(k), v);
            check("reset value", v, rv[k]);
        end
        for (int k = 0; k < 10; k++)
        begin
            a = 3'($urandom_range(0, 4));
            d = 8'($urandom);
            wr(a, d);
            rd(a, v);
            check("readback", v, d & MSK[a]);
        end
        // random writes may have started the timer; start the lock test from a clean state
        rst(2);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_SHADOW, 8'h5A);
        wr(ADDR_CONTROL, 8'h0C);
        wr(ADDR_SHADOW, 8'hA5);
        wr(ADDR_TIMER, 8'h33);
        wr(3'h7, 8'hFF);
        rd(ADDR_SHADOW, v);
        check("shadow locked in pwm", v, 8'h5A);
        rd(ADDR_TIMER, v);
        check("timer read-only", v, 8'h00);
        rd(3'h7, v);
        check("unmapped", v, 8'h00);
        $display("register test done");
        run(CFG_SINGLE, 0, PS_SEL_1, 3, 0, 2'h0);
        run(CFG_SINGLE, 10'h3FF, PS_SEL_4, 5, 0, 2'h0);
        run(CFG_HALF, 20, PS_SEL_1, 7, 4, 2'h3);
        run(CFG_HALF, 40, 2'h2, 3, 2, 2'h1);
        run(CFG_FWD, 30, PS_SEL_4, 9, 5, 2'h2);
        run(CFG_REV, 17, PS_SEL_1, 4, 3, 2'h0);
        for (int k = 0; k < 6; k++)
        begin
            per = $urandom_range(3, 15);
            run(2'($urandom_range(0, 3)), $urandom_range(1, 4 * per + 3), 2'($urandom_range(0, 2)), per,
                $urandom_range(0, 8), 2'($urandom_range(0, 3)));
        end
        run(CFG_SINGLE, 36, PS_SEL_1, 15, 0, 2'h0);
        wait_pin(0, 1'b0, 200);
        wait_pin(0, 1'b1, 200);
        wr(ADDR_DUTY_MSB, 8'h03);
        wr(ADDR_SHADOW, 8'h77);
        rd(ADDR_SHADOW, v);
        check("shadow before boundary", v, 8'h09);
        rd(ADDR_TIMER, v);
        check("timer within period", 16'(v <= 8'h0F), 16'h0001);
        repeat (70) @(posedge i_clk);
        rd(ADDR_SHADOW, v);
        check("shadow after boundary", v, 8'h03);
        $display("double buffer test done");
        for (int k = 0; k < 2; k++)
        begin
            run(CFG_FWD, 8, 2'(k), 7, 0, 2'h0);
            dir_change(CFG_REV, 1 + 3 * k);
            dir_change(CFG_FWD, 1 + 3 * k);
            $display("direction test %0d done", k);
        end
        give_verdict();
    end
endmodule

`default_nettype wire
